/* design/gather_pkg.sv */
package gather_pkg;
  localparam int ADDR_W      = 32;
  localparam int WORD_W      = 32;
  localparam int MEM_W       = 64;
  localparam int LANES       = 8;
  localparam int HALF_LANES  = 4;
  // address bit that picks the 32-bit half of a 64-bit memory word
  localparam int HALF_BIT    = 2;
  localparam int ALIGN_LSB   = 3;
  localparam int MEM_LATENCY = 2;
  localparam int LAT_W       = 4;
  localparam logic [LAT_W-1:0] LAT_COUNT = LAT_W'(MEM_LATENCY);
  localparam logic [LANES-1:0] ALL_FROM_MEM = 8'hFF;
  localparam logic [LANES-1:0] ALL_FROM_SYS = 8'h00;
  localparam logic [HALF_LANES-1:0] HALF_ONES = 4'hF;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_FULL_WRITE,
    OP_MERGE_WRITE,
    OP_READ
  } mem_op_type;
endpackage : gather_pkg

/* design/hard_error_isolator.sv */
`timescale 1ns/10ps
`default_nettype none
// compares the captured error word with its inverted re-read
module hard_error_isolator
#(
  parameter int WIDTH = 64
)
(
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] captured_error_word_i,
  input  wire logic [WIDTH-1:0] reread_inverted_word_i,
  output logic      [WIDTH-1:0] stuck_mask_o,
  output logic                  stuck_valid_o
);
  typedef struct packed {
    logic [WIDTH-1:0] mask;
    logic             valid;
  } iso_state_type;

  iso_state_type state;
  iso_state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.valid = load_i;
    if (load_i)
    begin
      // zero bits are positions that did not follow the inversion
      next_state.mask = reread_inverted_word_i ^ captured_error_word_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign stuck_mask_o  = state.mask;
  assign stuck_valid_o = state.valid;
endmodule : hard_error_isolator
`default_nettype wire

/* design/word_gather_edc_bridge.sv */
`timescale 1ns/10ps
`default_nettype none
module word_gather_edc_bridge
#(
  parameter int ADDR_W = gather_pkg::ADDR_W,
  parameter int WORD_W = gather_pkg::WORD_W
)
(
  input  wire logic                         clock_i,
  input  wire logic                         reset_i,
  input  wire logic                         wr_req_i,
  input  wire logic [ADDR_W-1:0]            wr_addr_i,
  input  wire logic [WORD_W-1:0]            wr_data_i,
  input  wire logic                         flush_i,
  output logic                              wr_ready_o,
  input  wire logic                         rd_req_i,
  input  wire logic [ADDR_W-1:0]            rd_addr_i,
  output logic                              rd_ready_o,
  output logic                              rd_valid_o,
  output logic [WORD_W-1:0]                 rd_data_o,
  input  wire logic                         scrub_req_i,
  input  wire logic [ADDR_W-1:0]            scrub_addr_i,
  input  wire logic                         isolate_req_i,
  input  wire logic [ADDR_W-1:0]            isolate_addr_i,
  output logic                              busy_o,
  output logic                              partial_write_o,
  output logic [ADDR_W-1:0]                 mem_addr_o,
  output logic                              mem_read_o,
  output logic                              mem_write_o,
  input  wire logic                         mem_done_i,
  output logic [gather_pkg::MEM_W-1:0]      system_side_data_bus_o,
  output logic [gather_pkg::LANES-1:0]      system_side_data_bus_oe_o,
  input  wire logic [gather_pkg::MEM_W-1:0] system_side_data_bus_i,
  output logic                              memory_side_oe_o,
  output logic [gather_pkg::LANES-1:0]      byte_lane_select_o,
  output logic                              error_readback_mode_o,
  input  wire logic [gather_pkg::MEM_W-1:0] captured_error_word_i,
  output logic [gather_pkg::MEM_W-1:0]      stuck_mask_o,
  output logic                              stuck_valid_o
);
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_MERGE_A,
    ST_MERGE_B,
    ST_FULL,
    ST_READ,
    ST_SCRUB_RD,
    ST_SCRUB_WR,
    ST_ISO_CAP,
    ST_ISO_WR,
    ST_ISO_RD
  } phase_type;

  typedef struct packed {
    phase_type                       phase;
    logic                            a_full;
    logic                            b_full;
    logic [ADDR_W-1:0]               a_addr;
    logic [WORD_W-1:0]               a_data;
    logic [ADDR_W-1:0]               b_addr;
    logic [WORD_W-1:0]               b_data;
    logic [ADDR_W-1:0]               rd_addr;
    logic [gather_pkg::MEM_W-1:0]    cap_word;
    logic [gather_pkg::MEM_W-1:0]    reread;
    logic [ADDR_W-1:0]               mem_addr;
    logic                            mem_read;
    logic                            mem_write;
    logic                            partial;
    logic [gather_pkg::MEM_W-1:0]    sys_bus;
    logic [gather_pkg::LANES-1:0]    sys_oe;
    logic                            mem_oe;
    logic [gather_pkg::LANES-1:0]    lane_sel;
    logic                            err_mode;
    logic                            wr_ready;
    logic                            rd_ready;
    logic                            rd_valid;
    logic [WORD_W-1:0]               rd_data;
    logic                            busy;
    logic                            iso_load;
  } bridge_state_type;

  bridge_state_type state;
  bridge_state_type next_state;

  function automatic logic upper_half(input logic [ADDR_W-1:0] addr);
    upper_half = addr[gather_pkg::HALF_BIT];
  endfunction : upper_half

  // gatherable pair: same aligned 64-bit word, opposite halves
  function automatic logic gatherable(input logic [ADDR_W-1:0] first,
                                      input logic [ADDR_W-1:0] second);
    gatherable = (first[ADDR_W-1:gather_pkg::ALIGN_LSB] == second[ADDR_W-1:gather_pkg::ALIGN_LSB])
                 && (upper_half(first) != upper_half(second));
  endfunction : gatherable

  // place one word in its half; the other half's lanes come from memory
  function automatic logic [gather_pkg::LANES-1:0] half_lanes(input logic [ADDR_W-1:0] addr);
    half_lanes = upper_half(addr) ? {gather_pkg::HALF_ONES, 4'h0} : {4'h0, gather_pkg::HALF_ONES};
  endfunction : half_lanes

  always_comb
  begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    next_state.iso_load = 1'b0;
    next_state.wr_ready = 1'b0;
    next_state.rd_ready = 1'b0;
    case (state.phase)
      ST_IDLE:
      begin
        next_state.mem_read  = 1'b0;
        next_state.mem_write = 1'b0;
        next_state.partial   = 1'b0;
        next_state.sys_oe    = gather_pkg::ALL_FROM_SYS;
        next_state.mem_oe    = 1'b0;
        next_state.err_mode  = 1'b0;
        next_state.busy      = 1'b0;
        if (state.a_full && state.b_full)
        begin
          next_state.busy = 1'b1;
          if (gatherable(state.a_addr, state.b_addr))
          begin
            // crossbar: each buffer goes to the half its address names
            next_state.sys_bus = upper_half(state.a_addr) ? {state.a_data, state.b_data}
                                                          : {state.b_data, state.a_data};
            next_state.mem_addr  = state.a_addr;
            next_state.lane_sel  = gather_pkg::ALL_FROM_SYS;
            next_state.sys_oe    = gather_pkg::ALL_FROM_SYS;
            next_state.mem_oe    = 1'b1;
            next_state.mem_write = 1'b1;
            next_state.phase     = ST_FULL;
          end
          else
          begin
            next_state.partial  = 1'b1;
            next_state.mem_addr = state.a_addr;
            next_state.sys_bus  = {state.a_data, state.a_data};
            next_state.lane_sel = ~half_lanes(state.a_addr);
            next_state.mem_read = 1'b1;
            next_state.phase    = ST_MERGE_A;
          end
        end
        else if (state.a_full && flush_i)
        begin
          next_state.busy     = 1'b1;
          next_state.partial  = 1'b1;
          next_state.mem_addr = state.a_addr;
          next_state.sys_bus  = {state.a_data, state.a_data};
          next_state.lane_sel = ~half_lanes(state.a_addr);
          next_state.mem_read = 1'b1;
          next_state.phase    = ST_MERGE_A;
        end
        else if (!state.a_full && rd_req_i)
        begin
          // reads never compare addresses, whole word always fetched
          next_state.busy     = 1'b1;
          next_state.rd_addr  = rd_addr_i;
          next_state.mem_addr = rd_addr_i;
          next_state.mem_read = 1'b1;
          next_state.phase    = ST_READ;
        end
        else if (!state.a_full && isolate_req_i)
        begin
          next_state.busy     = 1'b1;
          next_state.err_mode = 1'b1;
          next_state.mem_addr = isolate_addr_i;
          next_state.phase    = ST_ISO_CAP;
        end
        else if (!state.a_full && scrub_req_i)
        begin
          next_state.busy     = 1'b1;
          next_state.mem_addr = scrub_addr_i;
          next_state.mem_read = 1'b1;
          next_state.phase    = ST_SCRUB_RD;
        end
        else if (wr_req_i && !state.b_full)
        begin
          // holding buffers keep both address and data; first held for compare
          if (!state.a_full)
          begin
            next_state.a_addr = wr_addr_i;
            next_state.a_data = wr_data_i;
            next_state.a_full = 1'b1;
          end
          else
          begin
            next_state.b_addr = wr_addr_i;
            next_state.b_data = wr_data_i;
            next_state.b_full = 1'b1;
          end
          next_state.wr_ready = 1'b1;
        end
        else
        begin
          next_state.rd_ready = 1'b0;
        end
      end
      ST_MERGE_A, ST_MERGE_B:
      begin
        if (mem_done_i && state.mem_read)
        begin
          // the memory side merges by byte_lane_select_o; the unit drives only its word, in both halves
          next_state.mem_read  = 1'b0;
          next_state.mem_write = 1'b1;
          next_state.sys_oe    = gather_pkg::ALL_FROM_SYS;
          next_state.mem_oe    = 1'b1;
        end
        else if (mem_done_i && state.mem_write)
        begin
          next_state.mem_write = 1'b0;
          next_state.mem_oe    = 1'b0;
          if (state.phase == ST_MERGE_A && state.b_full)
          begin
            next_state.a_full   = 1'b0;
            next_state.mem_addr = state.b_addr;
            next_state.sys_bus  = {state.b_data, state.b_data};
            next_state.lane_sel = ~half_lanes(state.b_addr);
            next_state.mem_read = 1'b1;
            next_state.phase    = ST_MERGE_B;
          end
          else
          begin
            next_state.a_full  = 1'b0;
            next_state.b_full  = 1'b0;
            next_state.partial = 1'b0;
            next_state.phase   = ST_IDLE;
          end
        end
      end
      ST_FULL:
      begin
        if (mem_done_i)
        begin
          next_state.mem_write = 1'b0;
          next_state.mem_oe    = 1'b0;
          next_state.a_full    = 1'b0;
          next_state.b_full    = 1'b0;
          next_state.phase     = ST_IDLE;
        end
      end
      ST_READ:
      begin
        if (mem_done_i)
        begin
          next_state.mem_read = 1'b0;
          next_state.rd_data  = upper_half(state.rd_addr)
                                ? system_side_data_bus_i[gather_pkg::MEM_W-1:WORD_W]
                                : system_side_data_bus_i[WORD_W-1:0];
          next_state.rd_valid = 1'b1;
          next_state.rd_ready = 1'b1;
          next_state.phase    = ST_IDLE;
        end
      end
      ST_SCRUB_RD:
      begin
        if (mem_done_i)
        begin
          // word read is written back with every lane taken from the memory side (ALL_FROM_MEM)
          next_state.mem_read  = 1'b0;
          next_state.mem_write = 1'b1;
          next_state.lane_sel  = gather_pkg::ALL_FROM_MEM;
          next_state.mem_oe    = 1'b1;
          next_state.phase     = ST_SCRUB_WR;
        end
      end
      ST_ISO_CAP:
      begin
        next_state.cap_word  = captured_error_word_i;
        next_state.err_mode  = 1'b0;
        next_state.sys_bus   = ~captured_error_word_i;
        next_state.lane_sel  = gather_pkg::ALL_FROM_SYS;
        next_state.mem_oe    = 1'b1;
        next_state.mem_write = 1'b1;
        next_state.phase     = ST_ISO_WR;
      end
      ST_ISO_WR, ST_SCRUB_WR:
      begin
        if (mem_done_i)
        begin
          next_state.mem_write = 1'b0;
          next_state.mem_oe    = 1'b0;
          next_state.mem_read  = (state.phase == ST_ISO_WR);
          next_state.phase     = (state.phase == ST_ISO_WR) ? ST_ISO_RD : ST_IDLE;
        end
      end
      ST_ISO_RD:
      begin
        if (mem_done_i)
        begin
          next_state.mem_read = 1'b0;
          // the memory side only holds read data in the done cycle, so keep it here
          next_state.reread   = system_side_data_bus_i;
          next_state.iso_load = 1'b1;
          next_state.phase    = ST_IDLE;
        end
      end
      default:
      begin
        next_state.phase = ST_IDLE;
      end
    endcase
  end

  // pipelining is never used; one access at a time, writes held in the unit's two buffers
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  hard_error_isolator
  #(
    .WIDTH (gather_pkg::MEM_W)
  )
  u_isolator
  (
    .clock_i                (clock_i),
    .reset_i                (reset_i),
    .load_i                 (state.iso_load),
    .captured_error_word_i  (state.cap_word),
    .reread_inverted_word_i (state.reread),
    .stuck_mask_o           (stuck_mask_o),
    .stuck_valid_o          (stuck_valid_o)
  );

  assign wr_ready_o                = state.wr_ready;
  assign rd_ready_o                = state.rd_ready;
  assign rd_valid_o                = state.rd_valid;
  assign rd_data_o                 = state.rd_data;
  assign busy_o                    = state.busy;
  assign partial_write_o           = state.partial;
  assign mem_addr_o                = state.mem_addr;
  assign mem_read_o                = state.mem_read;
  assign mem_write_o               = state.mem_write;
  assign system_side_data_bus_o    = state.sys_bus;
  assign system_side_data_bus_oe_o = state.sys_oe;
  assign memory_side_oe_o          = state.mem_oe;
  assign byte_lane_select_o        = state.lane_sel;
  assign error_readback_mode_o     = state.err_mode;
endmodule : word_gather_edc_bridge
`default_nettype wire

/* dv/gather_check_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module gather_check
(
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        rd_valid_o,
  input wire logic        rd_ready_o,
  input wire logic        partial_write_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic        mem_read_o,
  input wire logic        mem_write_o,
  input wire logic        mem_done_i,
  input wire logic [63:0] system_side_data_bus_o,
  input wire logic [7:0]  system_side_data_bus_oe_o,
  input wire logic [63:0] system_side_data_bus_i,
  input wire logic        memory_side_oe_o,
  input wire logic [7:0]  byte_lane_select_o,
  input wire logic        error_readback_mode_o,
  input wire logic [63:0] captured_error_word_i,
  input wire logic [63:0] stuck_mask_o,
  input wire logic        stuck_valid_o
);
  default clocking dcb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  logic [31:0] rd_addr;
  logic [63:0] cap;
  logic [63:0] rr;
  sequence read_done_s;
    mem_read_o && mem_done_i;
  endsequence
  sequence err_mode_s;
    $rose(error_readback_mode_o) ##1 !error_readback_mode_o;
  endsequence
  // last read address and error words, kept for the write-back and stuck mask checks
  always_ff @(posedge clock_i)
  begin
    if (mem_read_o)
      rd_addr <= mem_addr_o;
    if (error_readback_mode_o)
      cap <= captured_error_word_i;
    if (mem_read_o && mem_done_i)
      rr <= system_side_data_bus_i;
  end
  read_done_a: assert property (rd_valid_o |-> $past(mem_read_o && mem_done_i))
    else $error("read valid without a finished memory read");
  ready_valid_a: assert property (rd_ready_o == rd_valid_o)
    else $error("read ready and read valid differ");
  write_drivers_a: assert property (mem_write_o |-> memory_side_oe_o
    && system_side_data_bus_oe_o == 8'h00) else $error("drivers wrong during write");
  no_overlap_a: assert property (!(mem_read_o && mem_write_o))
    else $error("memory read and write together");
  cycle_stands_a: assert property ((mem_read_o || mem_write_o) && !mem_done_i
    |=> $stable({mem_read_o, mem_write_o, mem_addr_o})) else $error("cycle dropped early");
  merge_addr_a: assert property ($rose(mem_write_o) && partial_write_o
    |-> mem_addr_o == rd_addr) else $error("merge write not at the location read");
  merge_lanes_a: assert property (partial_write_o && mem_write_o
    |-> byte_lane_select_o == (mem_addr_o[2] ? 8'h0F : 8'hF0)) else $error("merge lanes");
  full_lanes_a: assert property (mem_write_o && !partial_write_o
    |-> byte_lane_select_o inside {8'h00, 8'hFF}) else $error("full write lanes");
  iso_write_a: assert property (err_mode_s |-> ##[0:2]
    (mem_write_o && system_side_data_bus_o == ~cap)) else $error("no inverted write-back");
  stuck_mask_a: assert property (stuck_valid_o |-> stuck_mask_o == (rr ^ cap))
    else $error("stuck mask is not reread xor captured");
endmodule : gather_check
bind word_gather_edc_bridge gather_check chk_u
(
  .clock_i(clock_i), .reset_i(reset_i), .rd_valid_o(rd_valid_o),
  .rd_ready_o(rd_ready_o), .partial_write_o(partial_write_o), .mem_addr_o(mem_addr_o),
  .mem_read_o(mem_read_o), .mem_write_o(mem_write_o), .mem_done_i(mem_done_i),
  .system_side_data_bus_o(system_side_data_bus_o),
  .system_side_data_bus_oe_o(system_side_data_bus_oe_o),
  .system_side_data_bus_i(system_side_data_bus_i), .memory_side_oe_o(memory_side_oe_o),
  .byte_lane_select_o(byte_lane_select_o), .error_readback_mode_o(error_readback_mode_o),
  .captured_error_word_i(captured_error_word_i), .stuck_mask_o(stuck_mask_o),
  .stuck_valid_o(stuck_valid_o)
);
`default_nettype wire

/* dv/edc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module edc_mem_model
#(
  parameter logic [63:0] ERR_WORD = 64'hA5C3_0F96_1234_8E71,
  parameter logic [63:0] STUCK    = 64'h0000_00C8_0000_0400
)
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        slow_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [63:0] sys_i,
  input  wire logic [7:0]  lane_i,
  output logic             done_o,
  output logic [63:0]      data_o,
  output logic [63:0]      err_o
);
  logic [63:0] mem [16];
  logic [63:0] wv;
  logic [2:0]  cnt;
  assign err_o = ERR_WORD;
  always_comb
  begin
    for (int b = 0; b < 8; b++)
      wv[8*b+:8] = lane_i[b] ? mem[addr_i[6:3]][8*b+:8] : sys_i[8*b+:8];
    // the top word has hard faults: those bits ignore what is written
    if (addr_i[6:3] == 4'hF)
      wv = (wv & ~STUCK) | (ERR_WORD & STUCK);
  end
  always_ff @(posedge clock_i)
  begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (reset_i)
    begin
      cnt <= 3'h0;
      data_o <= 64'h0;
      for (int i = 0; i < 16; i++)
        mem[i] <= 64'h0;
    end
    else if ((read_i || write_i) && !done_o)
    begin
      cnt <= cnt + 3'h1;
      if (cnt >= (slow_i ? 3'h4 : 3'h0))
      begin
        cnt <= 3'h0;
        done_o <= 1'b1;
        if (read_i)
          data_o <= mem[addr_i[6:3]];
        else
          mem[addr_i[6:3]] <= wv;
      end
    end
  end
endmodule : edc_mem_model
`default_nettype wire

/* dv/word_gather_edc_bridge_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module word_gather_edc_bridge_bench;
  localparam logic [63:0] STUCK = 64'h0000_00C8_0000_0400;
  logic        clock_i, reset_i, wr_req_i, flush_i, rd_req_i, scrub_req_i, isolate_req_i;
  logic        slow, wr_ready_o, rd_ready_o, rd_valid_o, busy_o, partial_write_o;
  logic        mem_read_o, mem_write_o, mem_done_i, memory_side_oe_o;
  logic        error_readback_mode_o, stuck_valid_o;
  logic [31:0] wr_addr_i, wr_data_i, rd_addr_i, scrub_addr_i, isolate_addr_i;
  logic [31:0] rd_data_o, mem_addr_o;
  logic [63:0] sys_o, sys_i, err_w, stuck_mask_o;
  logic [7:0]  sys_oe, lanes;
  logic [31:0] ref_mem [16][2];
  int          bad_count, checks_done, w1, w2;
  integer      seed;
  word_gather_edc_bridge dut_u
  (
    .clock_i(clock_i), .reset_i(reset_i), .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .flush_i(flush_i), .wr_ready_o(wr_ready_o),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .scrub_req_i(scrub_req_i),
    .scrub_addr_i(scrub_addr_i), .isolate_req_i(isolate_req_i),
    .isolate_addr_i(isolate_addr_i), .busy_o(busy_o), .partial_write_o(partial_write_o),
    .mem_addr_o(mem_addr_o), .mem_read_o(mem_read_o), .mem_write_o(mem_write_o),
    .mem_done_i(mem_done_i), .system_side_data_bus_o(sys_o),
    .system_side_data_bus_oe_o(sys_oe), .system_side_data_bus_i(sys_i),
    .memory_side_oe_o(memory_side_oe_o), .byte_lane_select_o(lanes),
    .error_readback_mode_o(error_readback_mode_o), .captured_error_word_i(err_w),
    .stuck_mask_o(stuck_mask_o), .stuck_valid_o(stuck_valid_o)
  );
  edc_mem_model #(.STUCK(STUCK)) mem_u
  (
    .clock_i(clock_i), .reset_i(reset_i), .slow_i(slow), .read_i(mem_read_o),
    .write_i(mem_write_o), .addr_i(mem_addr_o), .sys_i(sys_o), .lane_i(lanes),
    .done_o(mem_done_i), .data_o(sys_i), .err_o(err_w)
  );
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] addr_of(input int w, input int h);
    return {25'h0, w[3:0], h[0], 2'b00};
  endfunction : addr_of
  function automatic logic got(input int k);
    return k == 0 ? wr_ready_o : k == 1 ? rd_valid_o : k == 2 ? stuck_valid_o : busy_o;
  endfunction : got
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic go;
    @(posedge clock_i);
    #1;
  endtask : go
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do
    begin
      go();
      n++;
    end
    while (n < 300 && got(k) !== 1'b1);
    if (n >= 300)
    begin
      bad_count++;
      $display("mismatch handshake %0d expected 1 seen 0", k);
      tally_and_finish();
    end
  endtask : wait_for
  task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp32
  task automatic cmp64(input string what, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp64
  // later writes overwrite the model copy, so request order decides the result
  task automatic wr(input int w, input int h, input logic [31:0] d);
    go();
    slow = 1'($random(seed));
    wr_req_i = 1'b1;
    wr_addr_i = addr_of(w, h);
    wr_data_i = d;
    ref_mem[w][h] = d;
    wait_for(0);
    wr_req_i = 1'b0;
  endtask : wr
  task automatic rd(input int w, input int h);
    go();
    slow = 1'($random(seed));
    rd_req_i = 1'b1;
    rd_addr_i = addr_of(w, h);
    wait_for(1);
    cmp32("read data", ref_mem[w][h], rd_data_o);
    rd_req_i = 1'b0;
  endtask : rd
  initial
  begin
    {wr_req_i, flush_i, rd_req_i, scrub_req_i, isolate_req_i, slow} = 6'h00;
    {wr_addr_i, wr_data_i, rd_addr_i, scrub_addr_i} = 128'h0;
    isolate_addr_i = addr_of(15, 0);
    bad_count = 0;
    checks_done = 0;
    seed = 33;
    for (int i = 0; i < 16; i++)
      ref_mem[i] = '{32'h0, 32'h0};
    reset_i = 1'b1;
    repeat (20) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    wr(2, 1, 32'hCAFE_0001);
    wr(2, 0, 32'h1234_5678);
    wr(4, 0, 32'h0BAD_F00D);
    wr(6, 1, 32'hFACE_B00C);
    wr(7, 0, 32'h1111_2222);
    wr(7, 0, 32'h3333_4444);
    for (int i = 0; i < 40; i++)
    begin
      w1 = $unsigned($random(seed)) % 15;
      w2 = ($random(seed) & 1) ? w1 : $unsigned($random(seed)) % 15;
      wr(w1, $random(seed) & 1, $random(seed));
      wr(w2, $random(seed) & 1, $random(seed));
    end
    wr(9, 1, 32'h0F0F_A5A5);
    go();
    flush_i = 1'b1;
    wait_for(3);
    flush_i = 1'b0;
    for (int w = 0; w < 15; w++)
      for (int h = 0; h < 2; h++)
        rd(w, h);
    go();
    scrub_req_i = 1'b1;
    scrub_addr_i = addr_of(2, 0);
    wait_for(3);
    scrub_req_i = 1'b0;
    rd(2, 0);
    rd(2, 1);
    go();
    isolate_req_i = 1'b1;
    wait_for(3);
    // drop the level request once taken so the sequence does not start again
    isolate_req_i = 1'b0;
    wait_for(2);
    cmp64("stuck mask", ~STUCK, stuck_mask_o);
    repeat (5) go();
    tally_and_finish();
  end
endmodule : word_gather_edc_bridge_bench
`default_nettype wire
